// [verilog/mtlb_core.sv]
`default_nettype none
module mtlb_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire mtlb_pkg::mtlb_taps_t tap_in,
  input wire logic tap_valid,
  input wire logic frame_start,
  output mtlb_pkg::mtlb_taps_t pix_out,
  output logic pix_valid,
  output logic [1:0] pix_taps,
  output logic shutter_close
);
  import mtlb_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  mtlb_taps_t tap_s1, tap_s2;
  logic valid_s1, valid_s2, fs_s1, fs_s2, fs_prev;
  logic frame_edge, eval;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tap_s1 <= '0;
      tap_s2 <= '0;
      valid_s1 <= 1'b0;
      valid_s2 <= 1'b0;
      fs_s1 <= 1'b0;
      fs_s2 <= 1'b0;
      fs_prev <= 1'b0;
      eval <= 1'b0;
    end else begin
      tap_s1 <= tap_in;
      tap_s2 <= tap_s1;
      valid_s1 <= tap_valid;
      valid_s2 <= valid_s1;
      fs_s1 <= frame_start;
      fs_s2 <= fs_s1;
      fs_prev <= fs_s2;
      eval <= frame_edge;
    end
  end

  assign frame_edge = fs_s2 & ~fs_prev;

  //////////////////////////////////////////////////////////////////////////
  // register file over AHB-Lite
  logic [31:0] config_reg;
  mtlb_pair_t man_gain, man_offset;
  logic [7:0] ref_level;
  logic [7:0] id_mem [0:ID_CHARS-1];
  logic wr_pend;
  logic [7:0] wr_addr;
  logic addr_ok;
  logic cmd_offset, cmd_gain, cmd_clear;
  mtlb_pair_t act_gain, act_offset;
  mtlb_acq_t acq_state;
  logic [3:0] acq_frames;

  assign addr_ok = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_ok & hwrite;
      wr_addr <= haddr[7:0];
      // zero wait states, always OKAY
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_reg <= CONFIG_RESET;
      man_gain <= {GAIN_UNITY, GAIN_UNITY};
      man_offset <= {OFFSET_ZERO, OFFSET_ZERO};
      ref_level <= REF_LEVEL_RESET;
    end else if (wr_pend) begin
      if (wr_addr == OFS_CONFIG) begin
        config_reg <= hwdata;
      end else if (wr_addr == OFS_MAN_GAIN) begin
        man_gain <= hwdata[15:0];
      end else if (wr_addr == OFS_MAN_OFFSET) begin
        man_offset <= hwdata[15:0];
      end else if (wr_addr == OFS_REF_LEVEL) begin
        ref_level <= hwdata[7:0];
      end
    end
  end

  // identification string, byte 0 in low lane of first word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < ID_CHARS; i++) begin
        id_mem[i] <= 8'h00;
      end
    end else if (wr_pend && wr_addr >= OFS_ID_BASE &&
                 wr_addr <= OFS_ID_LAST) begin
      for (int i = 0; i < ID_CHARS; i++) begin
        if (i / 4 == int'(wr_addr[3:2])) begin
          id_mem[i] <= hwdata[(i % 4) * 8 +: 8];
        end
      end
    end
  end

  // command strobes, one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_offset <= 1'b0;
      cmd_gain <= 1'b0;
      cmd_clear <= 1'b0;
    end else begin
      cmd_offset <= wr_pend && wr_addr == OFS_COMMAND &&
                    hwdata[CMD_ACQ_OFFSET_BIT];
      cmd_gain <= wr_pend && wr_addr == OFS_COMMAND &&
                  hwdata[CMD_ACQ_GAIN_BIT];
      cmd_clear <= wr_pend && wr_addr == OFS_COMMAND &&
                   hwdata[CMD_CLEAR_BIT];
    end
  end

  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (haddr[7:0] == OFS_CONFIG) begin
      next_rdata = config_reg;
    end else if (haddr[7:0] == OFS_STATUS) begin
      next_rdata = {24'h00_0000, acq_frames, shutter_close, 1'b0,
                    acq_state};
    end else if (haddr[7:0] == OFS_MAN_GAIN) begin
      next_rdata = {16'h0000, man_gain};
    end else if (haddr[7:0] == OFS_MAN_OFFSET) begin
      next_rdata = {16'h0000, man_offset};
    end else if (haddr[7:0] == OFS_REF_LEVEL) begin
      next_rdata = {24'h00_0000, ref_level};
    end else if (haddr[7:0] == OFS_ACT_GAIN) begin
      next_rdata = {16'h0000, act_gain};
    end else if (haddr[7:0] == OFS_ACT_OFFSET) begin
      next_rdata = {16'h0000, act_offset};
    end else if (haddr[7:0] >= OFS_ID_BASE &&
                 haddr[7:0] <= OFS_ID_LAST) begin
      for (int i = 0; i < ID_CHARS; i++) begin
        if (i / 4 == int'(haddr[3:2])) begin
          next_rdata[(i % 4) * 8 +: 8] = id_mem[i];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // gain and offset selection
  logic cont_on, shot_on;
  mtlb_pair_t cont_gain, shot_gain, shot_offset;
  mtlb_pair_t work_gain, work_offset;

  assign cont_on = config_reg[CFG_CONT_BIT];
  assign shot_on = config_reg[CFG_ONESHOT_BIT];

  always_comb begin
    if (acq_state == ACQ_GAIN) begin
      act_gain = {work_gain.right, man_gain.left};
    end else if (cont_on) begin
      act_gain = cont_gain;
    end else if (shot_on) begin
      act_gain = shot_gain;
    end else begin
      act_gain = man_gain;
    end
    if (acq_state == ACQ_OFFSET) begin
      act_offset = work_offset;
    end else if (shot_on) begin
      act_offset = shot_offset;
    end else begin
      act_offset = man_offset;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // correction datapath; upper pairs with right, lower with left
  function automatic logic [7:0] mtlb_corr(input logic [7:0] pix,
                                          input logic [7:0] gain,
                                          input logic [7:0] offs);
    logic [15:0] prod;
    logic signed [10:0] sum;
    prod = pix * gain;
    sum = signed'({2'h0, prod[15:7]}) + 11'(signed'(offs));
    if (sum < 0) begin
      return 8'h00;
    end else if (sum > 11'sh0FF) begin
      return 8'hFF;
    end
    return sum[7:0];
  endfunction

  logic use_lr, use_ud;
  assign use_lr = config_reg[1:0] != TAP_SINGLE;
  assign use_ud = config_reg[1:0] == TAP_QUAD;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pix_out <= '0;
      pix_valid <= 1'b0;
      pix_taps <= TAP_QUAD;
    end else begin
      pix_valid <= valid_s2;
      pix_taps <= config_reg[1:0];
      pix_out.right <= mtlb_corr(tap_s2.right, act_gain.right,
                                 act_offset.right);
      // downstream places quarters so they meet at the centre
      pix_out.left <= use_lr ? mtlb_corr(tap_s2.left, act_gain.left,
                                         act_offset.left) : 8'h00;
      pix_out.upper <= use_ud ? mtlb_corr(tap_s2.upper, act_gain.right,
                                          act_offset.right) : 8'h00;
      pix_out.lower <= use_ud ? mtlb_corr(tap_s2.lower, act_gain.left,
                                          act_offset.left) : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-frame level measurement on corrected right and left
  logic [27:0] sum_r, sum_l, frame_sum_r, frame_sum_l;
  logic [19:0] pix_cnt, frame_cnt;
  logic meas_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum_r <= 28'h000_0000;
      sum_l <= 28'h000_0000;
      pix_cnt <= 20'h0_0000;
      frame_sum_r <= 28'h000_0000;
      frame_sum_l <= 28'h000_0000;
      frame_cnt <= 20'h0_0000;
    end else if (frame_edge) begin
      frame_sum_r <= sum_r;
      frame_sum_l <= sum_l;
      frame_cnt <= pix_cnt;
      sum_r <= 28'h000_0000;
      sum_l <= 28'h000_0000;
      pix_cnt <= 20'h0_0000;
    end else if (pix_valid && pix_cnt != 20'hF_FFFF) begin
      sum_r <= sum_r + 28'(pix_out.right);
      sum_l <= sum_l + 28'(pix_out.left);
      pix_cnt <= pix_cnt + 20'h0_0001;
    end
  end

  // results are used one cycle after the frame edge
  assign meas_ok = eval && frame_cnt != 20'h0_0000;

  logic [27:0] ref_total, dark_total;
  assign ref_total = ref_level * frame_cnt;
  assign dark_total = DARK_LEVEL * frame_cnt;

  function automatic logic [7:0] mtlb_step_u(input logic [7:0] v,
                                             input logic up,
                                             input logic down);
    if (up && v != 8'hFF) begin
      return v + 8'h01;
    end else if (down && v != 8'h01) begin
      return v - 8'h01;
    end
    return v;
  endfunction

  function automatic logic [7:0] mtlb_step_s(input logic [7:0] v,
                                             input logic up,
                                             input logic down);
    if (up && v != 8'h7F) begin
      return v + 8'h01;
    end else if (down && v != 8'h80) begin
      return v - 8'h01;
    end
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // continuous gain loop, frozen while mode bit is clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cont_gain <= {GAIN_UNITY, GAIN_UNITY};
    end else if (cont_on && meas_ok) begin
      cont_gain.right <= mtlb_step_u(cont_gain.right,
                                     frame_sum_r < ref_total,
                                     frame_sum_r > ref_total);
      cont_gain.left <= mtlb_step_u(cont_gain.left,
                                    frame_sum_l < ref_total,
                                    frame_sum_l > ref_total);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // one-shot acquisition; a new acquire command is ignored while one runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acq_state <= ACQ_IDLE;
      acq_frames <= 4'h0;
      shutter_close <= 1'b0;
      work_gain <= {GAIN_UNITY, GAIN_UNITY};
      work_offset <= {OFFSET_ZERO, OFFSET_ZERO};
    end else begin
      case (acq_state)
        ACQ_IDLE: begin
          acq_frames <= 4'h0;
          if (cmd_offset) begin
            acq_state <= ACQ_OFFSET;
            shutter_close <= 1'b1;
            work_offset <= shot_offset;
          end else if (cmd_gain) begin
            acq_state <= ACQ_GAIN;
            work_gain <= {shot_gain.right, man_gain.left};
          end
        end
        ACQ_OFFSET: begin
          if (meas_ok) begin
            work_offset.right <= mtlb_step_s(work_offset.right,
                                             frame_sum_r < dark_total,
                                             frame_sum_r > dark_total);
            work_offset.left <= mtlb_step_s(work_offset.left,
                                            frame_sum_l < dark_total,
                                            frame_sum_l > dark_total);
            acq_frames <= acq_frames + 4'h1;
            if (acq_frames == ACQ_FRAMES - 4'h1) begin
              acq_state <= ACQ_IDLE;
              shutter_close <= 1'b0;
            end
          end
        end
        ACQ_GAIN: begin
          if (meas_ok) begin
            work_gain.right <= mtlb_step_u(work_gain.right,
                                           frame_sum_r < frame_sum_l,
                                           frame_sum_r > frame_sum_l);
            acq_frames <= acq_frames + 4'h1;
            if (acq_frames == ACQ_FRAMES - 4'h1) begin
              acq_state <= ACQ_IDLE;
            end
          end
        end
        default: begin
          acq_state <= ACQ_IDLE;
          shutter_close <= 1'b0;
        end
      endcase
    end
  end

  logic acq_last;
  assign acq_last = meas_ok && acq_frames == ACQ_FRAMES - 4'h1;

  // latched results; clear wins over a latch in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shot_gain <= {GAIN_UNITY, GAIN_UNITY};
      shot_offset <= {OFFSET_ZERO, OFFSET_ZERO};
    end else if (cmd_clear) begin
      shot_gain <= {GAIN_UNITY, GAIN_UNITY};
      shot_offset <= {OFFSET_ZERO, OFFSET_ZERO};
    end else if (acq_last && acq_state == ACQ_OFFSET) begin
      shot_offset.right <= mtlb_step_s(work_offset.right,
                                       frame_sum_r < dark_total,
                                       frame_sum_r > dark_total);
      shot_offset.left <= mtlb_step_s(work_offset.left,
                                      frame_sum_l < dark_total,
                                      frame_sum_l > dark_total);
    end else if (acq_last && acq_state == ACQ_GAIN) begin
      shot_gain.right <= mtlb_step_u(work_gain.right,
                                     frame_sum_r < frame_sum_l,
                                     frame_sum_r > frame_sum_l);
    end
  end
endmodule
`default_nettype wire

// [common/mtlb_pkg.sv]
// Operation
// - keep identification string, 15 characters, readable
// - identification reached only through serial commands; the code maps it as AHB registers at offsets 0x20 to 0x2C
// - balancing off after reset
// - four-tap quarters merged at frame centre
// - balancing off uses manual gain, offset
// - reference target level, reset 160
// - continuous mode steers gain every frame
// - continuous leaves offset; one-shot offset used
// - continuous active only while config bit 12
// - continuous mode ignores one-shot gain
// - one-shot values applied only with bit 11
// - one-shot values measured after acquire command
// - offset acquire closes shutter, steers dark level
// - offset acquire stops after count, latches
// - gain acquire steers right gain to left
// - gain acquire stops after count, latches
// - clear command resets one-shot gain, offset
// - four-port mode reads all four taps
// - two-port mode reads right and left
// - single-port mode reads one tap only
`default_nettype none
package mtlb_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MAN_GAIN = 8'h0C;
  localparam logic [7:0] OFS_MAN_OFFSET = 8'h10;
  localparam logic [7:0] OFS_REF_LEVEL = 8'h14;
  localparam logic [7:0] OFS_ACT_GAIN = 8'h18;
  localparam logic [7:0] OFS_ACT_OFFSET = 8'h1C;
  localparam logic [7:0] OFS_ID_BASE = 8'h20;
  localparam logic [7:0] OFS_ID_LAST = 8'h2C;
  // field positions
  localparam int CFG_CONT_BIT = 12;
  localparam int CFG_ONESHOT_BIT = 11;
  localparam int CMD_ACQ_OFFSET_BIT = 0;
  localparam int CMD_ACQ_GAIN_BIT = 1;
  localparam int CMD_CLEAR_BIT = 2;
  localparam int ID_CHARS = 15;
  // reset values
  localparam logic [1:0] TAP_SINGLE = 2'h0;
  localparam logic [1:0] TAP_DUAL = 2'h1;
  localparam logic [1:0] TAP_QUAD = 2'h2;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0002;
  localparam logic [7:0] REF_LEVEL_RESET = 8'hA0;
  localparam logic [7:0] GAIN_UNITY = 8'h80;
  localparam logic [7:0] OFFSET_ZERO = 8'h00;
  localparam logic [7:0] DARK_LEVEL = 8'h10;
  // frame counts
  localparam logic [3:0] ACQ_FRAMES = 4'h8;
  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_OFFSET = 2'b01,
    ACQ_GAIN = 2'b10
  } mtlb_acq_t;
  typedef struct packed {
    logic [7:0] right;
    logic [7:0] left;
    logic [7:0] upper;
    logic [7:0] lower;
  } mtlb_taps_t;
  typedef struct packed {
    logic [7:0] right;
    logic [7:0] left;
  } mtlb_pair_t;
endpackage
`default_nettype wire

// [verification/mtlb_tap_source.sv]
`default_nettype none
module mtlb_tap_source (
  input wire logic hclk,
  input wire logic [1:0] mode,
  input wire mtlb_pkg::mtlb_taps_t bright,
  input wire mtlb_pkg::mtlb_taps_t dark,
  input wire logic shutter_close,
  output mtlb_pkg::mtlb_taps_t tap_in,
  output logic tap_valid,
  output logic frame_start
);
  timeunit 1ns;
  timeprecision 1ps;
  import mtlb_pkg::*;
  int pos = 0;
  initial begin
    tap_in = '0;
    tap_valid = 1'b0;
    frame_start = 1'b0;
  end
  // mode 1 steady line, mode 2 framed: 2 marker, 2 gap, 16 pixels, 4 gap
  always @(posedge hclk) begin
    pos <= (mode == 2'h2 && pos != 23) ? pos + 1 : 0;
    frame_start <= mode == 2'h2 && pos < 2;
    if (mode == 2'h1 || (mode == 2'h2 && pos >= 4 && pos < 20)) begin
      tap_valid <= 1'b1;
      tap_in <= shutter_close ? dark : bright;
    end else begin
      tap_valid <= 1'b0;
      // released lines toggle so stale pixels are never mistaken
      tap_in <= ~tap_in;
    end
  end
endmodule
`default_nettype wire

// [verification/mtlb_core_sva.sv]
`default_nettype none
module mtlb_core_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tap_valid,
  input wire logic frame_start,
  input wire mtlb_pkg::mtlb_taps_t pix_out,
  input wire logic pix_valid,
  input wire logic [1:0] pix_taps,
  input wire logic shutter_close
);
  timeunit 1ns;
  timeprecision 1ps;
  import mtlb_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic cmd_ph;
  logic fs_d;
  logic [3:0] since_ofs;
  logic [4:0] shut_frames;
  logic id_rd;
  assign id_rd = hsel && hready && htrans[1] && !hwrite
    && haddr[7:0] == OFS_ID_LAST;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cmd_ph <= 1'b0;
    else if (hready) cmd_ph <= hsel && htrans[1] && hwrite
      && haddr[7:0] == OFS_COMMAND;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) since_ofs <= 4'hF;
    else if (cmd_ph && hready && hwdata[CMD_ACQ_OFFSET_BIT])
      since_ofs <= 4'h0;
    else if (since_ofs != 4'hF) since_ofs <= since_ofs + 4'h1;
  end
  // raw marker edges; the core sees them two cycles later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fs_d <= 1'b0;
      shut_frames <= 5'h00;
    end else begin
      fs_d <= frame_start;
      if (!shutter_close) shut_frames <= 5'h00;
      else if (frame_start && !fs_d) shut_frames <= shut_frames + 5'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_id_last_zero: assert property (id_rd |=> hrdata[31:24] == 8'h00)
    else $error("sixteenth id character stored");
  a_valid_rise: assert property (tap_valid |-> ##3 pix_valid)
    else $error("pixel strobe lost");
  a_valid_fall: assert property (!tap_valid |-> ##3 !pix_valid)
    else $error("pixel strobe invented");
  a_single_zero: assert property ((pix_taps == TAP_SINGLE)[*4] |->
    pix_out.left == 8'h00 && pix_out.upper == 8'h00
    && pix_out.lower == 8'h00) else $error("extra taps in single mode");
  a_dual_zero: assert property ((pix_taps == TAP_DUAL)[*4] |->
    pix_out.upper == 8'h00 && pix_out.lower == 8'h00)
    else $error("upper or lower tap in dual mode");
  a_shutter_cause: assert property ($rose(shutter_close) |->
    since_ofs <= 4'h6) else $error("shutter closed without command");
  a_shutter_ends: assert property (shutter_close |->
    shut_frames <= 5'h0C) else $error("offset acquisition never ends");
  a_shutter_count: assert property ($fell(shutter_close) |->
    shut_frames >= 5'h08) else $error("offset acquisition ended early");
  c_shutter: cover property ($rose(shutter_close));
  c_single: cover property (pix_taps == TAP_SINGLE && pix_valid);
  c_id_read: cover property (id_rd);
endmodule
bind mtlb_core mtlb_core_chk u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .tap_valid, .frame_start, .pix_out, .pix_valid, .pix_taps,
  .shutter_close);
`default_nettype wire

// [verification/test_multi_tap_level_balance.sv]
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  bad_count++; $display("unexpected at %0t: got %h want %h", $time, \
  got, exp); end end
module test_multi_tap_level_balance;
  timeunit 1ns;
  timeprecision 1ps;
  import mtlb_pkg::*;
  typedef struct packed {
    logic [31:0] cfg, gain, offs;
    mtlb_taps_t taps, exp;
  } mtlb_row_t;
  localparam mtlb_row_t ROWS [4] = '{
    '{32'h2, 32'h8080, 32'h0, 32'h0A141E28, 32'h0A141E28},
    '{32'h2, 32'hC040, 32'h05FD, 32'h80802010, 32'hC53D3505},
    '{32'h1, 32'hC040, 32'h05FD, 32'hF0025566, 32'hFF000000},
    '{32'h0, 32'hC040, 32'h05FD, 32'h3344AABB, 32'h51000000}};
  // pair registers hold right in bits 15:8, left in bits 7:0
  logic [7:0] ra [7] = '{OFS_CONFIG, OFS_MAN_GAIN, OFS_MAN_OFFSET,
    OFS_REF_LEVEL, OFS_ACT_GAIN, OFS_ACT_OFFSET, 8'h40};
  logic [31:0] re [7] = '{32'h2, 32'h8080, 32'h0, 32'hA0, 32'h8080,
    32'h0, 32'h0};
  // printable characters only: "CAM-RIGHT+07abcX"
  logic [31:0] id_w [4] = '{32'h2D4D4143, 32'h48474952, 32'h37302B54,
    32'h58636261};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, tap_valid, frame_start;
  logic pix_valid, shutter_close;
  logic [1:0] htrans, pix_taps, mode;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, g1;
  mtlb_taps_t tap_in, pix_out, bright, dark;
  int bad_count = 0;
  int check_count = 0;
  always #20 hclk = ~hclk;
  mtlb_core u_mtlb_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tap_in(tap_in),
    .tap_valid(tap_valid), .frame_start(frame_start), .pix_out(pix_out),
    .pix_valid(pix_valid), .pix_taps(pix_taps),
    .shutter_close(shutter_close));
  mtlb_tap_source u_mtlb_tap_source (.hclk(hclk), .mode(mode),
    .bright(bright), .dark(dark), .shutter_close(shutter_close),
    .tap_in(tap_in), .tap_valid(tap_valid), .frame_start(frame_start));
  ////////////////////////////////////////////////////////////////////////
  task automatic cycles(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) timed_out();
  endtask
  // entered just after an edge; ends one idle cycle later so a
  // following read never sees a write of the same data phase
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic wait_shutter(input logic lvl);
    int n;
    n = 0;
    while (shutter_close !== lvl && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    if (shutter_close !== lvl) timed_out();
  endtask
  task automatic wait_idle();
    int n;
    logic [31:0] q;
    n = 0;
    cycles(3);
    do begin
      bus(1'b0, OFS_STATUS, 32'h0, q);
      n++;
    end while (q[1:0] !== 2'h0 && n < 300);
    if (q[1:0] !== 2'h0) timed_out();
  endtask
  task automatic stop_test();
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // a wait limit that runs out ends the run as a failure
  task automatic timed_out();
    bad_count++;
    stop_test();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    mode = 2'h0;
    bright = '0;
    dark = 32'h061A0000;
    cycles(4);
    hresetn <= 1'b1;
    foreach (ROWS[i]) begin
      wr(OFS_MAN_GAIN, ROWS[i].gain);
      wr(OFS_MAN_OFFSET, ROWS[i].offs);
      wr(OFS_CONFIG, ROWS[i].cfg);
      bright <= ROWS[i].taps;
      mode <= 2'h1;
      cycles(8);
      `CHK(pix_out, ROWS[i].exp)
      `CHK(pix_valid, 1'b1)
      `CHK(pix_taps, ROWS[i].cfg[1:0])
    end
    // second reset in mid-stream, then every reset value except status and id
    mode <= 2'h0;
    hresetn <= 1'b0;
    cycles(4);
    `CHK({pix_taps, shutter_close}, 3'h4)
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) chk_rd(ra[i], re[i]);
    for (int i = 0; i < 4; i++) wr(8'(OFS_ID_BASE + 4 * i), id_w[i]);
    for (int i = 0; i < 3; i++) chk_rd(8'(OFS_ID_BASE + 4 * i), id_w[i]);
    chk_rd(OFS_ID_LAST, 32'h00636261);
    bright <= 32'h40601020;
    wr(OFS_COMMAND, 32'h1);
    wait_shutter(1'b1);
    chk_rd(OFS_STATUS, 32'h9);
    mode <= 2'h2;
    wait_shutter(1'b0);
    chk_rd(OFS_ACT_OFFSET, 32'h0);
    wr(OFS_CONFIG, 32'h802);
    chk_rd(OFS_ACT_OFFSET, 32'h08F8);
    wr(OFS_COMMAND, 32'h2);
    wait_idle();
    chk_rd(OFS_ACT_GAIN, 32'h8880);
    wr(OFS_CONFIG, 32'h1802);
    bus(1'b0, OFS_ACT_GAIN, 32'h0, g1);
    cycles(80);
    bus(1'b0, OFS_ACT_GAIN, 32'h0, rd);
    `CHK(rd[7:0] > g1[7:0], 1'b1)
    chk_rd(OFS_ACT_OFFSET, 32'h08F8);
    wr(OFS_CONFIG, 32'h802);
    chk_rd(OFS_ACT_GAIN, 32'h8880);
    wr(OFS_COMMAND, 32'h4);
    chk_rd(OFS_ACT_GAIN, 32'h8080);
    chk_rd(OFS_ACT_OFFSET, 32'h0);
    mode <= 2'h0;
    stop_test();
  end
endmodule
`default_nettype wire
